/* logic/bbcfg_pkg.sv */
/*
  shared constants and carriers for the buck-boost setpoint and dither configuration block.
  assumes a 25 MHz core clock and a byte-wide register port decoded by an external serial slave.
*/
`default_nettype none
package bbcfg_pkg;
  // register offsets
  localparam logic [7:0] OFS_REF_CODE = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h01;
  localparam logic [7:0] OFS_DITHER_CONFIG = 8'h04;
  // field positions in output_control_config
  localparam int CONV_ON_BIT = 7;
  localparam int IN_RANGE_BIT = 6;
  localparam int RAMP_STEP_LSB = 3;
  localparam int FB_DIV_LSB = 0;
  // field positions in frequency_dither_config
  localparam int DITH_EN_BIT = 7;
  localparam int DITH_SPAN_LSB = 4;
  localparam int DITH_RATE_LSB = 0;
  // fallback values if no programmed defaults arrive
  localparam logic [7:0] REF_CODE_RST = 8'h00;
  localparam logic [7:0] OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] DITH_CFG_RST = 8'h00;
  // setpoint resolution in microvolts per code
  localparam int REF_LSB_UV = 10000;
  // clock rate and ramp step times in nanoseconds
  localparam int CLK_HZ = 25000000;
  localparam int CLK_NS = 40;
  localparam int STEP_NS_0 = 20000;
  localparam int STEP_NS_1 = 41670;
  localparam int STEP_NS_2 = 83330;
  localparam int STEP_NS_3 = 166670;
  localparam logic [15:0] STEP_CYC_0 = 16'((STEP_NS_0 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] STEP_CYC_1 = 16'((STEP_NS_1 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] STEP_CYC_2 = 16'((STEP_NS_2 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] STEP_CYC_3 = 16'((STEP_NS_3 + CLK_NS - 1) / CLK_NS);
  // spans in tenths of a percent
  localparam logic [9:0] SPAN_PM_0 = 10'd30;
  localparam logic [9:0] SPAN_PM_1 = 10'd50;
  localparam logic [9:0] SPAN_PM_2 = 10'd100;
  localparam logic [9:0] SPAN_PM_3 = 10'd125;
  localparam logic [9:0] SPAN_PM_4 = 10'd200;
  localparam logic [9:0] SPAN_PM_5 = 10'd250;
  localparam logic [9:0] SPAN_PM_6 = 10'd300;
  // modulation frequencies in hertz
  localparam int RATE_HZ_0 = 250;
  localparam int RATE_HZ_1 = 500;
  localparam int RATE_HZ_2 = 1000;
  localparam int RATE_HZ_3 = 2000;
  localparam int RATE_HZ_4 = 3000;
  localparam int RATE_HZ_5 = 4000;
  localparam int RATE_HZ_6 = 8000;
  localparam int RATE_HZ_7 = 9000;
  // triangle: 2*span steps per sweep, 4*span per period, span in tenths of a percent
  localparam int TRI_STEPS_PER_PM = 2;

  typedef struct packed {
    logic converter_on;
    logic input_range_select;
    logic reserved_bit;
    logic [1:0] ramp_step_time;
    logic [2:0] feedback_divide_select;
  } out_ctrl_t;

  typedef struct packed {
    logic dither_enable;
    logic [2:0] dither_span;
    logic reserved_bit;
    logic [2:0] dither_rate;
  } dith_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

/* logic/bbcfg_tri_gen.sv */
/*
  triangle generator for frequency dither: signed offset in tenths of a percent.
  assumes span and step period are static between reconfigurations; changes apply to the running sweep without a restart.
*/
`default_nettype none
module bbcfg_tri_gen (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [9:0] span,
  input wire logic [15:0] tick_cycles,
  output logic signed [10:0] offset
);
  typedef enum logic [0:0] {TRI_UP = 1'b0, TRI_DOWN = 1'b1} tri_dir_t;
  tri_dir_t dir_r, dir_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic signed [10:0] off_r, off_nxt;
  logic signed [10:0] hi;

  assign hi = signed'({1'b0, span});
  assign offset = off_r;

  always_comb begin
    dir_nxt = dir_r;
    tick_nxt = tick_r;
    off_nxt = off_r;
    if (!run) begin
      // park at the bottom so an enable starts from the lowest frequency
      dir_nxt = TRI_UP;
      tick_nxt = 16'h0000;
      off_nxt = -hi;
    end else if (tick_r >= tick_cycles) begin
      tick_nxt = 16'h0000;
      unique case (dir_r)
        TRI_UP: begin
          if (off_r >= hi) begin
            dir_nxt = TRI_DOWN;
            off_nxt = off_r - 11'sd1;
          end else begin
            off_nxt = off_r + 11'sd1;
          end
        end
        TRI_DOWN: begin
          if (off_r <= -hi) begin
            dir_nxt = TRI_UP;
            off_nxt = off_r + 11'sd1;
          end else begin
            off_nxt = off_r - 11'sd1;
          end
        end
      endcase
    end else begin
      tick_nxt = tick_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= TRI_UP;
      tick_r <= 16'h0000;
      off_r <= 11'sh000;
    end else begin
      dir_r <= dir_nxt;
      tick_r <= tick_nxt;
      off_r <= off_nxt;
    end
  end
endmodule
`default_nettype wire

/* logic/bbcfg_top.sv */
/*
  configuration logic of a four-switch buck-boost converter: setpoint, ramp, enables and dither.
  assumes a serial slave on the same clock delivers byte register accesses; the otp loader
  presents its defaults with a load strobe; the sync pin detector is asynchronous.
*/
`default_nettype none
module bbcfg_top (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // register port from serial slave
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  // programmed defaults
  input wire logic OTP_LOAD_IN,
  input wire logic [7:0] OTP_REF_IN,
  input wire logic [7:0] OTP_CTRL_IN,
  input wire logic [7:0] OTP_DITH_IN,
  // sync pin status
  input wire logic SYNC_MODE_IN,
  input wire logic SYNC_CLK_PRESENT_IN,
  // power stage controls
  output logic CONVERTER_ON_OUT,
  output logic LOW_INPUT_OUT,
  output logic [7:0] REF_STEP_OUT,
  output logic [2:0] FEEDBACK_DIVIDE_OUT,
  output logic [15:0] VOUT_TARGET_MV_OUT,
  output logic DITHER_ACTIVE_OUT,
  output logic signed [10:0] FREQ_OFFSET_PM_OUT
);
  bbcfg_pkg::reg_req_t req;
  bbcfg_pkg::out_ctrl_t ctrl_r, ctrl_nxt;
  bbcfg_pkg::dith_cfg_t dith_r, dith_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic [7:0] step_r, step_nxt;
  logic [15:0] ramp_cnt_r, ramp_cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] vout_r, vout_nxt;
  logic sync_m_r, sync_s_r, mode_m_r, mode_s_r;
  logic dith_run_r, dith_run_nxt;
  logic [15:0] step_cycles;
  logic [4:0] div_factor;
  logic [9:0] span_pm;
  logic [15:0] tri_tick;
  logic signed [10:0] tri_offset;
  logic signed [10:0] freq_off_r, freq_off_nxt;
  logic [31:0] vout_prod;
  int rate_hz;

  assign req = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN};

  // field decodes
  always_comb begin
    unique case (ctrl_r.ramp_step_time)
      2'd0: step_cycles = bbcfg_pkg::STEP_CYC_0;
      2'd1: step_cycles = bbcfg_pkg::STEP_CYC_1;
      2'd2: step_cycles = bbcfg_pkg::STEP_CYC_2;
      2'd3: step_cycles = bbcfg_pkg::STEP_CYC_3;
    endcase
    unique case (ctrl_r.feedback_divide_select)
      3'd0: div_factor = 5'd1;
      3'd1: div_factor = 5'd2;
      3'd2: div_factor = 5'd3;
      3'd3: div_factor = 5'd5;
      3'd4: div_factor = 5'd10;
      3'd5: div_factor = 5'd20;
      default: div_factor = 5'd30;
    endcase
    unique case (dith_r.dither_span)
      3'd0: span_pm = bbcfg_pkg::SPAN_PM_0;
      3'd1: span_pm = bbcfg_pkg::SPAN_PM_1;
      3'd2: span_pm = bbcfg_pkg::SPAN_PM_2;
      3'd3: span_pm = bbcfg_pkg::SPAN_PM_3;
      3'd4: span_pm = bbcfg_pkg::SPAN_PM_4;
      3'd5: span_pm = bbcfg_pkg::SPAN_PM_5;
      default: span_pm = bbcfg_pkg::SPAN_PM_6;
    endcase
    unique case (dith_r.dither_rate)
      3'd0: rate_hz = bbcfg_pkg::RATE_HZ_0;
      3'd1: rate_hz = bbcfg_pkg::RATE_HZ_1;
      3'd2: rate_hz = bbcfg_pkg::RATE_HZ_2;
      3'd3: rate_hz = bbcfg_pkg::RATE_HZ_3;
      3'd4: rate_hz = bbcfg_pkg::RATE_HZ_4;
      3'd5: rate_hz = bbcfg_pkg::RATE_HZ_5;
      3'd6: rate_hz = bbcfg_pkg::RATE_HZ_6;
      3'd7: rate_hz = bbcfg_pkg::RATE_HZ_7;
    endcase
    // cycles per triangle step: period spread over 4*span unit steps, minus the step cycle
    tri_tick = 16'(bbcfg_pkg::CLK_HZ / (rate_hz * bbcfg_pkg::TRI_STEPS_PER_PM * 2
                                          * int'(span_pm)) - 1);
  end

  // register file and read path
  always_comb begin
    ctrl_nxt = ctrl_r;
    dith_nxt = dith_r;
    ref_nxt = ref_r;
    rdata_nxt = rdata_r;
    if (OTP_LOAD_IN) begin
      ref_nxt = OTP_REF_IN;
      ctrl_nxt = bbcfg_pkg::out_ctrl_t'(OTP_CTRL_IN);
      dith_nxt = bbcfg_pkg::dith_cfg_t'(OTP_DITH_IN);
    end else if (req.wr) begin
      unique case (req.addr)
        bbcfg_pkg::OFS_REF_CODE: ref_nxt = req.wdata;
        bbcfg_pkg::OFS_OUTPUT_CONTROL: ctrl_nxt = bbcfg_pkg::out_ctrl_t'(req.wdata);
        bbcfg_pkg::OFS_DITHER_CONFIG: dith_nxt = bbcfg_pkg::dith_cfg_t'(req.wdata);
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        bbcfg_pkg::OFS_REF_CODE: rdata_nxt = ref_r;
        bbcfg_pkg::OFS_OUTPUT_CONTROL: rdata_nxt = ctrl_r;
        bbcfg_pkg::OFS_DITHER_CONFIG: rdata_nxt = dith_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_r <= bbcfg_pkg::out_ctrl_t'(bbcfg_pkg::OUT_CTRL_RST);
      dith_r <= bbcfg_pkg::dith_cfg_t'(bbcfg_pkg::DITH_CFG_RST);
      ref_r <= bbcfg_pkg::REF_CODE_RST;
      rdata_r <= 8'h00;
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      mode_m_r <= 1'b0;
      mode_s_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      dith_r <= dith_nxt;
      ref_r <= ref_nxt;
      rdata_r <= rdata_nxt;
      sync_m_r <= SYNC_CLK_PRESENT_IN;
      sync_s_r <= sync_m_r;
      mode_m_r <= SYNC_MODE_IN;
      mode_s_r <= mode_m_r;
    end
  end

  // setpoint ramp, target voltage and dither output
  always_comb begin
    step_nxt = step_r;
    ramp_cnt_nxt = ramp_cnt_r;
    // soft start from zero when off; moves one code per step time toward the reference
    if (!ctrl_r.converter_on) begin
      step_nxt = 8'h00;
      ramp_cnt_nxt = 16'h0000;
    end else if (step_r == ref_r) begin
      ramp_cnt_nxt = 16'h0000;
    end else if (ramp_cnt_r >= step_cycles - 16'h0001) begin
      ramp_cnt_nxt = 16'h0000;
      step_nxt = (step_r < ref_r) ? step_r + 8'h01 : step_r - 8'h01;
    end else begin
      ramp_cnt_nxt = ramp_cnt_r + 16'h0001;
    end
    // in mV: code*10mV*div; widest is 255*10*30 = 76500, clipped to 16 bits by saturation
    vout_prod = 32'(step_r) * 32'(bbcfg_pkg::REF_LSB_UV / 1000) * 32'(div_factor);
    vout_nxt = (vout_prod > 32'h0000_FFFF) ? 16'hFFFF : vout_prod[15:0];
    dith_run_nxt = dith_r.dither_enable && !(mode_s_r && sync_s_r);
    // flopped output trails dither_active by one cycle
    freq_off_nxt = dith_run_r ? tri_offset : 11'sh000;
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      step_r <= 8'h00;
      ramp_cnt_r <= 16'h0000;
      vout_r <= 16'h0000;
      dith_run_r <= 1'b0;
      freq_off_r <= 11'sh000;
    end else begin
      step_r <= step_nxt;
      ramp_cnt_r <= ramp_cnt_nxt;
      vout_r <= vout_nxt;
      dith_run_r <= dith_run_nxt;
      freq_off_r <= freq_off_nxt;
    end
  end

  bbcfg_tri_gen u_tri (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .run(dith_run_r),
    .span(span_pm),
    .tick_cycles(tri_tick),
    .offset(tri_offset)
  );

  // outputs straight from flip-flops
  assign REG_RDATA_OUT = rdata_r;
  assign CONVERTER_ON_OUT = ctrl_r.converter_on;
  assign LOW_INPUT_OUT = ctrl_r.input_range_select;
  assign REF_STEP_OUT = step_r;
  assign FEEDBACK_DIVIDE_OUT = ctrl_r.feedback_divide_select;
  assign VOUT_TARGET_MV_OUT = vout_r;
  assign DITHER_ACTIVE_OUT = dith_run_r;
  // offset held at zero when dither is off so the frequency stays fixed
  assign FREQ_OFFSET_PM_OUT = freq_off_r;
endmodule
`default_nettype wire

/* testbench/bbcfg_monitor.sv */
/*
  concurrent checks on the ports of the setpoint and dither configuration block.
  assumes one clock domain and the asynchronous active-low reset of the top module.
*/
`default_nettype none
module bbcfg_monitor (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // register port
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  // programmed defaults
  input wire logic OTP_LOAD_IN,
  input wire logic [7:0] OTP_REF_IN,
  input wire logic [7:0] OTP_CTRL_IN,
  input wire logic [7:0] OTP_DITH_IN,
  // sync status
  input wire logic SYNC_MODE_IN,
  input wire logic SYNC_CLK_PRESENT_IN,
  // power stage controls
  input wire logic CONVERTER_ON_OUT,
  input wire logic LOW_INPUT_OUT,
  input wire logic [7:0] REF_STEP_OUT,
  input wire logic [2:0] FEEDBACK_DIVIDE_OUT,
  input wire logic [15:0] VOUT_TARGET_MV_OUT,
  input wire logic DITHER_ACTIVE_OUT,
  input wire logic signed [10:0] FREQ_OFFSET_PM_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // a config write can reshape or park the sweep, so slope checks wait for a quiet spell
  logic [1:0] quiet_r;
  logic [1:0] quiet_nxt;
  always_comb begin
    quiet_nxt = (REG_WR_IN || OTP_LOAD_IN) ? 2'h0 : ((quiet_r == 2'h3) ? 2'h3 : quiet_r + 2'h1);
  end
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) quiet_r <= 2'h0;
    else quiet_r <= quiet_nxt;
  end
  function automatic logic [15:0] vexp(input logic [7:0] s, input logic [2:0] d);
    int dv[8] = '{1, 2, 3, 5, 10, 20, 30, 30};
    int p;
    p = int'(s) * 10 * dv[d];
    return (p > 65535) ? 16'hFFFF : 16'(p);
  endfunction
  wire ctl_wr = REG_WR_IN && REG_ADDR_IN == 8'h01 && !OTP_LOAD_IN;
  sequence calc_settled;
    ($stable(REF_STEP_OUT) && $stable(FEEDBACK_DIVIDE_OUT)) [*2];
  endsequence
  sequence sync_held;
    (SYNC_MODE_IN && SYNC_CLK_PRESENT_IN) [*4];
  endsequence
  sequence sweep_running;
    DITHER_ACTIVE_OUT && $past(DITHER_ACTIVE_OUT, 2) && quiet_r == 2'h3;
  endsequence
  chk_div_write: assert property (ctl_wr |=>
    FEEDBACK_DIVIDE_OUT == $past(REG_WDATA_IN[2:0]))
    else $error("divide select did not follow a write");
  chk_conv_write: assert property (ctl_wr |=> CONVERTER_ON_OUT == $past(REG_WDATA_IN[7]))
    else $error("converter enable did not follow a write");
  chk_low_in_write: assert property (ctl_wr |=> LOW_INPUT_OUT == $past(REG_WDATA_IN[6]))
    else $error("input range did not follow a write");
  chk_otp_load: assert property (OTP_LOAD_IN |=>
    FEEDBACK_DIVIDE_OUT == $past(OTP_CTRL_IN[2:0]))
    else $error("programmed default not loaded");
  chk_vout_calc: assert property (calc_settled |->
    VOUT_TARGET_MV_OUT == vexp(REF_STEP_OUT, FEEDBACK_DIVIDE_OUT))
    else $error("output target mismatch");
  chk_step_single: assert property ($changed(REF_STEP_OUT) |->
    REF_STEP_OUT == 8'($past(REF_STEP_OUT) + 8'h01) ||
    REF_STEP_OUT == 8'($past(REF_STEP_OUT) - 8'h01) || REF_STEP_OUT == 8'h00)
    else $error("setpoint jumped");
  chk_conv_off_step: assert property (!CONVERTER_ON_OUT [*2] |-> REF_STEP_OUT == 8'h00)
    else $error("setpoint held while off");
  chk_dither_idle: assert property (!DITHER_ACTIVE_OUT [*2] |->
    FREQ_OFFSET_PM_OUT == 11'sd0)
    else $error("offset moved while dither idle");
  chk_sync_suppress: assert property (sync_held |-> !DITHER_ACTIVE_OUT)
    else $error("dither active under external sync");
  chk_tri_slope: assert property (sweep_running and $changed(FREQ_OFFSET_PM_OUT) |->
    (int'(FREQ_OFFSET_PM_OUT) - int'($past(FREQ_OFFSET_PM_OUT))) inside {1, -1})
    else $error("sweep stepped by more than one");
  chk_unmapped_rd: assert property (REG_RD_IN &&
    !(REG_ADDR_IN inside {8'h00, 8'h01, 8'h04}) |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind bbcfg_top bbcfg_monitor bbcfg_monitor_i (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .OTP_LOAD_IN(OTP_LOAD_IN),
  .OTP_REF_IN(OTP_REF_IN), .OTP_CTRL_IN(OTP_CTRL_IN), .OTP_DITH_IN(OTP_DITH_IN),
  .SYNC_MODE_IN(SYNC_MODE_IN), .SYNC_CLK_PRESENT_IN(SYNC_CLK_PRESENT_IN),
  .CONVERTER_ON_OUT(CONVERTER_ON_OUT), .LOW_INPUT_OUT(LOW_INPUT_OUT),
  .REF_STEP_OUT(REF_STEP_OUT), .FEEDBACK_DIVIDE_OUT(FEEDBACK_DIVIDE_OUT),
  .VOUT_TARGET_MV_OUT(VOUT_TARGET_MV_OUT), .DITHER_ACTIVE_OUT(DITHER_ACTIVE_OUT),
  .FREQ_OFFSET_PM_OUT(FREQ_OFFSET_PM_OUT));
`default_nettype wire

/* testbench/testbench.sv */
/*
  self-checking bench for the setpoint and dither configuration block.
  assumes the byte register port with one-cycle strobes and one 25 MHz clock.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, otp = 1'b0, smode = 1'b0, sclk = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, oref = 8'h00, octl = 8'h00, odith = 8'h00;
  logic [7:0] rdata, step;
  logic conv, lowin, act;
  logic [2:0] fdiv;
  logic [15:0] vout;
  logic signed [10:0] offs, mn, mx;
  int n_errors = 0, n_compared = 0;
  always #20 clk = ~clk;
  bbcfg_top bbcfg_top_i (.CLK_IN(clk), .RST_B_IN(rst_b), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .OTP_LOAD_IN(otp),
    .OTP_REF_IN(oref), .OTP_CTRL_IN(octl), .OTP_DITH_IN(odith), .SYNC_MODE_IN(smode),
    .SYNC_CLK_PRESENT_IN(sclk), .CONVERTER_ON_OUT(conv), .LOW_INPUT_OUT(lowin),
    .REF_STEP_OUT(step), .FEEDBACK_DIVIDE_OUT(fdiv), .VOUT_TARGET_MV_OUT(vout),
    .DITHER_ACTIVE_OUT(act), .FREQ_OFFSET_PM_OUT(offs));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check("read data", 16'(rdata), 16'(e));
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    int dv[8] = '{1, 2, 3, 5, 10, 20, 30, 30};
    int stp[4] = '{500, 1042, 2084, 4167};
    int sp[8] = '{30, 50, 100, 125, 200, 250, 300, 300};
    int rt[8] = '{250, 500, 1000, 2000, 3000, 4000, 8000, 9000};
    int cnt;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rreg(8'h00, 8'h00);
    rreg(8'h01, 8'h00);
    rreg(8'h04, 8'h00);
    // programmed defaults must win over a same-cycle write
    @(posedge clk);
    {otp, wr, addr, wdata, oref, octl, odith} <= {2'b11, 8'h01, 8'hFF, 8'h05, 8'h45, 8'h17};
    @(posedge clk);
    {otp, wr} <= 2'b00;
    rreg(8'h00, 8'h05);
    rreg(8'h01, 8'h45);
    rreg(8'h04, 8'h17);
    wreg(8'h01, 8'h7F);
    rreg(8'h01, 8'h7F);
    check("low input", 16'(lowin), 16'h0001);
    wreg(8'h04, 8'h08);
    rreg(8'h04, 8'h08);
    wreg(8'h02, 8'hAA);
    rreg(8'h02, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wreg(8'h01, 8'h04);
      wreg(8'h00, 8'h01);
      wreg(8'h01, 8'(8'h84 | (k << 3)));
      cnt = 0;
      while (step !== 8'h01 && cnt < 6000) begin
        @(negedge clk);
        cnt++;
      end
      check("ramp step", 16'(cnt >= stp[k] - 3 && cnt <= stp[k] + 3), 16'h0001);
    end
    // back to the shortest step so the two-code ramp ends inside the idle span
    wreg(8'h01, 8'h84);
    wreg(8'h00, 8'h03);
    idle(1600);
    for (int d = 0; d < 8; d++) begin
      wreg(8'h01, 8'(8'h80 | d));
      idle(3);
      check("divide", 16'(fdiv), 16'(d));
      check("target", vout, 16'(30 * dv[d]));
    end
    wreg(8'h00, 8'h01);
    idle(1100);
    check("moved setpoint", 16'(step), 16'h0001);
    check("moved target", vout, 16'(10 * dv[7]));
    wreg(8'h01, 8'h07);
    idle(3);
    check("conv off", 16'({conv, step}), 16'h0000);
    for (int s = 0; s < 8; s++) begin
      wreg(8'h04, 8'(8'h87 | (s << 4)));
      mn = 11'sd0;
      mx = 11'sd0;
      repeat (3000) begin
        @(negedge clk);
        if (offs < mn) mn = offs;
        if (offs > mx) mx = offs;
      end
      check("dither on", 16'(act), 16'h0001);
      check("span high", 16'(mx), 16'(sp[s]));
      check("span low", 16'(mn), 16'(-sp[s]));
    end
    // one sweep step lasts a modulation period over 4*span steps; span code 0 gives 120
    for (int r = 0; r < 8; r++) begin
      wreg(8'h04, 8'(8'h80 | r));
      idle(1);
      for (int m = 0; m < 2; m++) begin
        mn = offs;
        cnt = 0;
        while (offs === mn && cnt < 1000) begin
          @(negedge clk);
          cnt++;
        end
      end
      cnt = cnt * rt[r] * 120 - 25000000;
      check("rate step", 16'(cnt > -rt[r] * 120 && cnt < rt[r] * 120), 16'h0001);
    end
    @(posedge clk);
    {smode, sclk} <= 2'b11;
    idle(6);
    check("sync active", 16'(act), 16'h0000);
    check("sync offset", 16'(offs), 16'h0000);
    @(posedge clk);
    sclk <= 1'b0;
    idle(6);
    check("mode only", 16'(act), 16'h0001);
    wreg(8'h04, 8'h07);
    idle(4);
    check("dither off", 16'({act, offs}), 16'h0000);
    complete_run();
  end
  // whole run is near 40000 cycles, so this margin only trips on a hang
  initial begin
    repeat (70000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
